// ==== rtl/converter_init_reset_sequencer.sv ====
// reset and initialisation sequencer of the dual-channel converter registers
// assumes the reset pin and reference-buffer pin are asynchronous to ref_clk;
// register writes come from the serial interface decoder on ref_clk
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// R1: reset pin high pulse resets registers
// R2: host sets reference pin, clock before reset
// R3: reset release loads fuses, starts calibration
// R4: host waits calibration before chip select
// R5: host waits 100 ns before reset edge
// R6: host waits 2 ms before reference level; the host model waits PWR_CYC cycles, 8 in the bench
// R7: writing D0 reloads defaults, self-clears
// R8: host keeps reset pin low during software reset
// R9: no register writes until calibration done
// R10: reset pulses under 1 us unreliable
module converter_init_reset_sequencer
  import init_seq_pkg::*;
#(
  // calibration length; a bench may shorten it to keep runs short
  parameter int unsigned CAL_COUNT = CAL_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        hw_reset_pin,
  input  wire logic        reference_buffer_select_pin,
  input  wire logic        serial_chip_select_n,
  input  wire reg_wr_t     reg_wr,
  output seq_status_t      status,
  output logic             reg_wr_accept,
  output logic             ref_buffer_level,
  output logic [7:0]       sw_reset_ctrl_rd
);

  typedef enum logic [1:0] {ST_IDLE, ST_RESET, ST_CAL, ST_READY} seq_state_t;

  // state flow:
  //   idle  -> reset  when the synchronised pin goes high
  //   reset -> cal    on a released pulse of full width
  //   reset -> idle   on a pulse that was too short
  //   cal   -> ready  when the hold-off timer expires
  //   ready -> cal    on a software reset write
  //   any   -> reset  while the pin is high
  // pin synchronisers
  logic        rst_s1_q;
  logic        rst_s2_q;
  logic        rst_s3_q;
  logic        ref_s1_q;
  logic        ref_s2_q;
  // pulse width check
  logic [PULSE_W-1:0] pulse_cnt_q;
  logic        pulse_ok_q;
  logic        hw_release;
  // calibration control
  logic        wr_to_ctrl;
  logic        sw_reset_hit;
  logic        cal_start;
  logic        cal_busy;
  logic        cal_done;
  logic [7:0]  sw_reset_ctrl_q;
  seq_state_t  state_q;
  seq_state_t  state_d;

  // decoded states, shared by the write gate and the status outputs
  logic        in_reset;
  logic        in_cal;
  logic        in_ready;

  // two-stage synchroniser for the reset pin; the third stage only feeds the edge detect
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
      rst_s3_q <= 1'b0;
    end else if (clk_en) begin
      rst_s1_q <= hw_reset_pin;
      rst_s2_q <= rst_s1_q;
      rst_s3_q <= rst_s2_q;
    end
  end

  // two-stage synchroniser for the reference-buffer level; a plain level, no edge stage
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_s1_q <= 1'b0;
      ref_s2_q <= 1'b0;
    end else if (clk_en) begin
      ref_s1_q <= reference_buffer_select_pin;
      ref_s2_q <= ref_s1_q;
    end
  end

  // latch the reference-buffer level only while reset is high, so it is set before calibration
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ref_buffer_level <= 1'b0;
    end else if (clk_en && rst_s2_q) begin
      ref_buffer_level <= ref_s2_q; // R2
    end
  end

  // measure the reset pulse width; short glitches are ignored
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulse_cnt_q <= '0;
      pulse_ok_q  <= 1'b0;
    end else if (clk_en) begin
      if (!rst_s2_q) begin
        pulse_cnt_q <= '0;
        pulse_ok_q  <= 1'b0;
      end else if (pulse_cnt_q != PULSE_W'(RST_PULSE_CYCLES)) begin
        pulse_cnt_q <= pulse_cnt_q + PULSE_W'(1);
      end else begin
        pulse_ok_q  <= 1'b1; // R10
      end
    end
  end

  // falling edge of the synchronised pin after a pulse of full width
  assign hw_release   = rst_s3_q && !rst_s2_q && pulse_ok_q; // R1
  // a write that addresses the reset register with the reset bit set
  assign wr_to_ctrl   = (reg_wr.addr == SW_RESET_CTRL_ADDR) && reg_wr.data[SW_RESET_BIT];
  // software reset is only honoured once ready and with the reset pin low
  assign sw_reset_hit = reg_wr.wr_en && reg_wr_accept && !rst_s2_q && wr_to_ctrl; // R7 R8

  // sequencer state
  always_comb begin
    state_d = state_q;
    case (state_q)
      // wait for the synchronised pin to go high
      ST_IDLE: begin
        if (rst_s2_q) state_d = ST_RESET;
      end
      // a released pulse of full width starts calibration; a short one is dropped
      ST_RESET: begin
        if (hw_release) begin
          state_d = ST_CAL; // R3
        end else if (!rst_s2_q) begin
          state_d = ST_IDLE;
        end
      end
      // the pin aborts a running calibration; otherwise wait for the timer
      ST_CAL: begin
        if (rst_s2_q) begin
          state_d = ST_RESET; // R1
        end else if (cal_done) begin
          state_d = ST_READY; // R9
        end
      end
      // registers usable; the pin or the reset bit starts over
      ST_READY: begin
        if (rst_s2_q) begin
          state_d = ST_RESET; // R1
        end else if (sw_reset_hit) begin
          state_d = ST_CAL; // R7
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // the state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // load defaults on a qualified release, or on the reset bit while ready
  assign cal_start = clk_en && ((in_reset && hw_release)
                     || (in_ready && sw_reset_hit && !rst_s2_q)); // R3

  // calibration hold-off timer
  cycle_timer #(
    .W     (CNT_W),
    .COUNT (CAL_COUNT)
  ) u_cal_timer (
    .ref_clk    (ref_clk),
    .sys_rst    (sys_rst),
    .clk_en     (clk_en),
    .start      (cal_start),
    .busy       (cal_busy),
    .done_pulse (cal_done)
  );

  // reset bit reads one for the cycle after the write, then self-clears
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sw_reset_ctrl_q <= SW_RESET_CTRL_RST;
    end else if (clk_en) begin
      if (cal_start) begin
        sw_reset_ctrl_q <= SW_RESET_CTRL_RST;
        sw_reset_ctrl_q[SW_RESET_BIT] <= sw_reset_hit; // R7
      end else begin
        sw_reset_ctrl_q <= SW_RESET_CTRL_RST; // R7
      end
    end
  end

  // state decode
  assign in_reset              = (state_q == ST_RESET);
  assign in_cal                = (state_q == ST_CAL);
  assign in_ready              = (state_q == ST_READY);

  // read-back of the reset register
  assign sw_reset_ctrl_rd      = sw_reset_ctrl_q;
  // writes are refused until calibration completes; chip select must be active too
  assign reg_wr_accept         = in_ready && !serial_chip_select_n; // R9 R4
  assign status.ready          = in_ready;
  // the timer is not stopped by an abort, so its busy flag only counts inside the run
  assign status.calibrating    = cal_busy && in_cal; // R1
  // pulse that tells the register bank to reload fuse defaults
  assign status.load_defaults  = cal_start; // R1 R3 R7

endmodule : converter_init_reset_sequencer
`default_nettype wire

// ==== rtl/cycle_timer.sv ====
// down-counting cycle timer used for the calibration hold-off
// assumes start and enable from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
module cycle_timer #(
  parameter int unsigned W     = 18,
  parameter int unsigned COUNT = 200000
) (
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy,
  output logic      done_pulse
);
  logic [W-1:0] cnt_q;

  // restart wins over a count in progress
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_q      <= '0;
      done_pulse <= 1'b0;
    end else if (clk_en) begin
      done_pulse <= 1'b0;
      if (start) begin
        cnt_q <= W'(COUNT);
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - W'(1);
        if (cnt_q == W'(1)) begin
          done_pulse <= 1'b1;
        end
      end
    end
  end

  assign busy = (cnt_q != '0);
endmodule : cycle_timer
`default_nettype wire

// ==== rtl/init_seq_pkg.sv ====
// constants and carrier types for the converter reset/initialisation sequencer
// assumes a single sampling clock domain at 25 MHz
package init_seq_pkg;

  localparam int unsigned CLK_PERIOD_NS     = 40;
  // calibration length in sampling-clock cycles
  localparam int unsigned CAL_CYCLES        = 200000;
  // shortest reset pulse treated as reliable
  localparam int unsigned RST_PULSE_MIN_NS  = 1000;
  localparam int unsigned RST_PULSE_CYCLES  =
    (RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register map
  localparam logic [7:0] SW_RESET_CTRL_ADDR = 8'h00;
  localparam int unsigned SW_RESET_BIT      = 0;
  localparam logic [7:0] SW_RESET_CTRL_RST  = 8'h00;

  localparam int unsigned CNT_W   = 18;
  localparam int unsigned PULSE_W = 6;

  // register write request from the serial interface
  typedef struct packed {
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  // sequencer status
  typedef struct packed {
    logic ready;
    logic calibrating;
    logic load_defaults;
  } seq_status_t;

endpackage : init_seq_pkg

// ==== test/converter_init_reset_sequencer_bench.sv ====
// bench for the reset sequencer
// assumes the host model drives both pins
`timescale 1ns/1ns
`default_nettype none
module converter_init_reset_sequencer_bench
  import init_seq_pkg::*;
;
  logic ref_clk = 1'b0, sys_rst = 1'b1, cs_n = 1'b1, hw_pin, ref_pin, acc, lvl;
  reg_wr_t wr = '0;
  seq_status_t st;
  logic [7:0] rd;
  // shortened calibration so two runs stay well inside the cycle budget
  localparam int unsigned BENCH_CAL = 200;
  int mismatches = 0, n_checks = 0, cyc = 0;
  initial forever #20 ref_clk = ~ref_clk;
  host_model #(.PWR_CYC(8)) i_host_model (.ref_clk(ref_clk), .hw_reset_pin(hw_pin),
    .reference_buffer_select_pin(ref_pin));
  converter_init_reset_sequencer #(.CAL_COUNT(BENCH_CAL)) i_converter_init_reset_sequencer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst), .clk_en(1'b1), .hw_reset_pin(hw_pin), .status(st),
    .reference_buffer_select_pin(ref_pin), .serial_chip_select_n(cs_n), .reg_wr(wr),
    .reg_wr_accept(acc), .ref_buffer_level(lvl), .sw_reset_ctrl_rd(rd));
  task results;
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task chk(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %b got %b", nm, e, g);
    end
  endtask : chk
  // two full calibrations fit under this ceiling
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results;
    end
  end
  task see_ld(input logic e);
    logic hit;
    hit = 1'b0;
    repeat (6) begin
      @(negedge ref_clk);
      if (st.load_defaults === 1'b1) hit = 1'b1;
    end
    chk("load_defaults", e, hit);
  endtask : see_ld
  task wait_ready;
    repeat (BENCH_CAL + 10) begin
      @(negedge ref_clk);
      if (st.ready === 1'b1) break;
    end
    chk("ready", 1'b1, st.ready);
  endtask : wait_ready
  // one write to the reset register, then the self-clearing bit
  task wr_reg(input logic [7:0] d, input logic c, input logic ea, input logic el);
    @(posedge ref_clk);
    cs_n <= c;
    wr <= '{wr_en: 1'b1, addr: SW_RESET_CTRL_ADDR, data: d};
    @(negedge ref_clk);
    chk("accept", ea, acc);
    chk("load_defaults", el, st.load_defaults);
    @(posedge ref_clk);
    wr.wr_en <= 1'b0;
    @(negedge ref_clk);
    chk("bit0", el, rd[0]);
    @(negedge ref_clk);
    chk("bit0", 1'b0, rd[0]);
  endtask : wr_reg
  initial begin
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    i_host_model.hw_pulse(1'b1, 30);
    see_ld(1'b1);
    chk("calibrating", 1'b1, st.calibrating);
    chk("ref_level", 1'b1, lvl);
    wr_reg(8'h01, 1'b0, 1'b0, 1'b0);
    wait_ready;
    wr_reg(8'h01, 1'b1, 1'b0, 1'b0);
    wr_reg(8'h00, 1'b0, 1'b1, 1'b0);
    wr_reg(8'h01, 1'b0, 1'b1, 1'b1);
    chk("calibrating", 1'b1, st.calibrating);
    wait_ready;
    i_host_model.hw_pulse(1'b0, 10);
    see_ld(1'b0);
    chk("ref_level", 1'b0, lvl);
    results;
  end
endmodule : converter_init_reset_sequencer_bench
`default_nettype wire

// ==== test/host_model.sv ====
// host model: drives the reset pin and reference-buffer pin
// assumes the bench calls hw_pulse after system reset
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int unsigned PWR_CYC = 8
) (
  input  wire logic ref_clk,
  output logic      hw_reset_pin,
  output logic      reference_buffer_select_pin
);
  initial begin
    hw_reset_pin = 1'b0;
    reference_buffer_select_pin = 1'b0;
  end
  // power-up wait is shortened to keep the run short
  task automatic hw_pulse(input logic lvl, input int n);
    repeat (PWR_CYC) @(posedge ref_clk);
    reference_buffer_select_pin <= lvl;
    repeat (3) @(posedge ref_clk);
    hw_reset_pin <= 1'b1;
    repeat (n) @(posedge ref_clk);
    hw_reset_pin <= 1'b0;
  endtask : hw_pulse
endmodule : host_model
`default_nettype wire

// ==== test/seq_assertions.sv ====
// checker for the reset sequencer ports
// assumes it is bound onto the sequencer top
`timescale 1ns/1ns
`default_nettype none
module seq_assertions
  import init_seq_pkg::*;
#(
  parameter int unsigned CAL_COUNT = CAL_CYCLES
) (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        hw_reset_pin,
  input wire logic        serial_chip_select_n,
  input wire logic        reg_wr_accept,
  input wire seq_status_t status,
  input wire logic [7:0]  sw_reset_ctrl_rd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic [17:0] cal_n;
  // length of the current calibration run
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) cal_n <= '0;
    else cal_n <= status.calibrating ? cal_n + 18'h1 : '0;
  end
  chk_accept_gate: assert property (
    reg_wr_accept |-> status.ready && !serial_chip_select_n) else $error("accept not ready");
  chk_cal_length: assert property (
    $fell(status.calibrating) && !hw_reset_pin |-> cal_n >= CAL_COUNT - 1
      && cal_n <= CAL_COUNT + 1) else $error("calibration length");
  chk_ready_after: assert property (
    $fell(status.calibrating) && !hw_reset_pin |-> ##[0:1] status.ready) else $error("no ready");
  chk_defaults_start: assert property (
    status.load_defaults |=> status.calibrating [*8]) else $error("no calibration");
  chk_bit_clear: assert property (
    sw_reset_ctrl_rd[0] |=> !sw_reset_ctrl_rd[0]) else $error("bit0 stuck");
  chk_pin_aborts: assert property (
    hw_reset_pin [*5] |-> !status.ready && !status.calibrating) else $error("no abort");
  cover property (status.load_defaults);
  cover property (reg_wr_accept);
  cover property (sw_reset_ctrl_rd[0]);
endmodule : seq_assertions
bind converter_init_reset_sequencer seq_assertions #(.CAL_COUNT(CAL_COUNT)) i_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst), .hw_reset_pin(hw_reset_pin), .status(status),
  .serial_chip_select_n(serial_chip_select_n), .reg_wr_accept(reg_wr_accept),
  .sw_reset_ctrl_rd(sw_reset_ctrl_rd));
`default_nettype wire
